/* src/aptc_map.svh */
// register offsets, field positions and reset values for the pair trigger control block
`ifndef APTC_MAP_SVH
`define APTC_MAP_SVH
`define APTC_OFF_CTRL_8_9 4'h0
`define APTC_OFF_CTRL_10_11 4'h1
`define APTC_OFF_IRQ_STATUS 4'h2
`define APTC_OFF_IRQ_MASK 4'h3
`define APTC_BIT_IRQEN 7
`define APTC_BIT_PEND 6
`define APTC_BIT_SWTRG 5
`define APTC_SEL_MSB 4
`define APTC_ODD_SHIFT 8
`define APTC_CTRL_RESET 16'h0000
`define APTC_IRQ_RESET 3'h0
`define APTC_SEL_OFF 5'h00
`define APTC_SEL_SOFT 5'h01
`define APTC_SEL_GLOBAL 5'h02
`define APTC_SEL_SPECIAL 5'h03
`define APTC_SEL_PRI_FIRST 5'h04
`define APTC_SEL_PRI_LAST 5'h0B
`define APTC_SEL_TMR1 5'h0C
`define APTC_SEL_SEC_FIRST 5'h0E
`define APTC_SEL_SEC_LAST 5'h16
`define APTC_SEL_CL_FIRST 5'h17
`define APTC_SEL_CL_LAST 5'h1E
`define APTC_SEL_TMR2 5'h1F
`endif

/* src/aptc_pkg.sv */
// types shared by the pair trigger control block
package aptc_pkg;
   typedef enum logic [1:0] {
      APTC_IDLE = 2'h0,
      APTC_BUSY = 2'h1
   } aptc_state_t;
   // one pair's software-visible slice
   typedef struct packed {
      logic irq_en;
      logic pending;
      logic soft_trig;
      logic [4:0] sel;
   } aptc_slice_t;
   // trigger sources from pwm and timers
   typedef struct packed {
      logic global_soft;
      logic special_event;
      logic [7:0] pwm_primary;
      logic [8:0] pwm_secondary;
      logic [7:0] pwm_climit;
      logic tmr1_period;
      logic tmr2_period;
   } aptc_trig_t;
endpackage

/* src/aptc_pair_trigger.sv */
// pair trigger control: three pair slices, selector, pending, fixed-priority request handshake and interrupt
//
// Operation
// - slices 8, 10, 11 govern inputs 16-17, 20-23
// - enabled pair sets its sticky status bit on completion; irq_o only if masked in
// - selected trigger sets the pending flag
// - completion clears the pending flag
// - soft trigger bit self-clears once pending
// - selector zero disables all triggers
// - code 1 own, code 2 global software
// - code 3 routes pwm special event
// - codes 4-11 pwm primary 1-8
// - code 12 timer1, code 13 reserved
// - codes 14-22 pwm secondary 1-9
// - codes 23-30 pwm current limit 1-8
// - code 31 selects timer2 period match
// - odd slice high byte, even low byte
`include "aptc_map.svh"
`timescale 1ns/10ps
`default_nettype none
module aptc_pair_trigger
   import aptc_pkg::*;
(
   input wire logic clock_i, // 250 MHz system clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic [3:0] addr_i, // register word index
   input wire logic [15:0] wdata_i, // write data
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   output logic [15:0] rdata_o, // read data, cycle after rd_i
   input wire aptc_trig_t trig_i, // trigger pulses from pwm and timers
   output logic conv_req_o, // conversion request to sequencer
   output logic [1:0] conv_pair_o, // pair index: 0=pair8 1=pair10 2=pair11
   input wire logic conv_ack_i, // sequencer accepted request
   input wire logic conv_done_i, // sequencer finished current pair
   output logic irq_o // level interrupt
);
   // pair slices; index 0 = pair 8, 1 = pair 10, 2 = pair 11
   aptc_slice_t slice_reg [3];
   aptc_slice_t slice_next [3];
   logic [4:0] sel9_reg; // odd half of the 8/9 register, storage only
   logic [2:0] status_reg;
   logic [2:0] status_next;
   logic [2:0] mask_reg;
   aptc_state_t state_reg;
   aptc_state_t state_next;
   logic [1:0] active_reg;
   logic [15:0] rdata_reg;

   // trigger multiplexer shared by all three slices
   function automatic logic trig_pick(input logic [4:0] sel, input logic own, input aptc_trig_t t);
      logic hit;
      hit = 1'b0;
      if (sel == `APTC_SEL_OFF) begin
         hit = 1'b0;
      end else if (sel == `APTC_SEL_SOFT) begin
         hit = own;
      end else if (sel == `APTC_SEL_GLOBAL) begin
         hit = t.global_soft;
      end else if (sel == `APTC_SEL_SPECIAL) begin
         hit = t.special_event;
      end else if (sel >= `APTC_SEL_PRI_FIRST && sel <= `APTC_SEL_PRI_LAST) begin
         hit = t.pwm_primary[3'(sel - `APTC_SEL_PRI_FIRST)];
      end else if (sel == `APTC_SEL_TMR1) begin
         hit = t.tmr1_period;
      end else if (sel >= `APTC_SEL_SEC_FIRST && sel <= `APTC_SEL_SEC_LAST) begin
         hit = t.pwm_secondary[4'(sel - `APTC_SEL_SEC_FIRST)];
      end else if (sel >= `APTC_SEL_CL_FIRST && sel <= `APTC_SEL_CL_LAST) begin
         hit = t.pwm_climit[3'(sel - `APTC_SEL_CL_FIRST)];
      end else if (sel == `APTC_SEL_TMR2) begin
         hit = t.tmr2_period;
      end
      return hit; // code 13 falls through: reserved, no trigger
   endfunction

   // byte image of one slice, bit layout is fixed by the register map
   function automatic logic [7:0] slice_img(input aptc_slice_t s);
      return {s.irq_en, s.pending, s.soft_trig, s.sel};
   endfunction

   // address decode
   wire wr_ctrl89 = wr_i && addr_i == `APTC_OFF_CTRL_8_9;
   wire wr_ctrl1011 = wr_i && addr_i == `APTC_OFF_CTRL_10_11;
   wire wr_status = wr_i && addr_i == `APTC_OFF_IRQ_STATUS;
   wire wr_mask = wr_i && addr_i == `APTC_OFF_IRQ_MASK;

   // software write data routed per slice
   wire [2:0] slice_wr = {wr_ctrl1011, wr_ctrl1011, wr_ctrl89};
   wire [7:0] slice_wdata [3];
   assign slice_wdata[0] = wdata_i[7:0];
   assign slice_wdata[1] = wdata_i[7:0];
   assign slice_wdata[2] = wdata_i[15:8];

   // trigger hits per slice; pair 8 owns inputs 16/17, 10 owns 20/21, 11 owns 22/23
   wire [2:0] hit;
   genvar g;
   for (g = 0; g < 3; g++) begin : gen_hit
      assign hit[g] = trig_pick(slice_reg[g].sel, slice_reg[g].soft_trig, trig_i);
   end

   // lowest pending pair wins the sequencer; pair 8 has highest priority
   wire [2:0] pend_vec = {slice_reg[2].pending, slice_reg[1].pending, slice_reg[0].pending};
   wire [1:0] pick = pend_vec[0] ? 2'h0 : (pend_vec[1] ? 2'h1 : 2'h2);
   wire done_now = state_reg == APTC_BUSY && conv_done_i;
   wire [2:0] done_vec = done_now ? 3'(3'h1 << active_reg) : 3'h0;

   // sequencer handshake: one pair in flight at a time
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         APTC_IDLE: begin
            if (conv_req_o && conv_ack_i) begin
               state_next = APTC_BUSY;
            end
         end
         APTC_BUSY: begin
            if (conv_done_i) begin
               state_next = APTC_IDLE;
            end
         end
         default: begin
            state_next = APTC_IDLE;
         end
      endcase
   end
   assign conv_req_o = state_reg == APTC_IDLE && |pend_vec;
   assign conv_pair_o = state_reg == APTC_IDLE ? pick : active_reg;

   // slice next state: software write, then hardware set/clear on top
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         slice_next[i] = slice_reg[i];
         if (slice_wr[i]) begin
            slice_next[i].irq_en = slice_wdata[i][`APTC_BIT_IRQEN];
            slice_next[i].soft_trig = slice_wdata[i][`APTC_BIT_SWTRG];
            slice_next[i].sel = slice_wdata[i][`APTC_SEL_MSB:0];
         end
         // pending is hardware-owned; a new trigger beats completion
         if (done_vec[i]) begin
            slice_next[i].pending = 1'b0;
         end
         if (hit[i]) begin
            slice_next[i].pending = 1'b1;
         end
         if (slice_reg[i].pending) begin
            slice_next[i].soft_trig = 1'b0;
         end
      end
   end

   // sticky interrupt status, set wins over write-one-clear
   wire [2:0] irq_event = done_vec & {slice_reg[2].irq_en, slice_reg[1].irq_en, slice_reg[0].irq_en};
   assign status_next = (status_reg & ~(wr_status ? wdata_i[2:0] : 3'h0)) | irq_event;

   // read mux
   wire [15:0] rd_mux =
      addr_i == `APTC_OFF_CTRL_8_9 ? {3'h0, sel9_reg, slice_img(slice_reg[0])} :
      addr_i == `APTC_OFF_CTRL_10_11 ? {slice_img(slice_reg[2]), slice_img(slice_reg[1])} :
      addr_i == `APTC_OFF_IRQ_STATUS ? {13'h0, status_reg} :
      addr_i == `APTC_OFF_IRQ_MASK ? {13'h0, mask_reg} : 16'h0000;

   // control registers; all clear at reset
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < 3; i++) begin
            slice_reg[i] <= aptc_slice_t'(8'(`APTC_CTRL_RESET));
         end
         sel9_reg <= 5'h00;
         status_reg <= `APTC_IRQ_RESET;
         mask_reg <= `APTC_IRQ_RESET;
      end else begin
         slice_reg <= slice_next;
         if (wr_ctrl89) begin
            sel9_reg <= wdata_i[`APTC_ODD_SHIFT + `APTC_SEL_MSB:`APTC_ODD_SHIFT];
         end
         status_reg <= status_next;
         if (wr_mask) begin
            mask_reg <= wdata_i[2:0];
         end
      end
   end

   // handshake state and read data
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= APTC_IDLE;
         active_reg <= 2'h0;
         rdata_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         if (conv_req_o && conv_ack_i) begin
            active_reg <= pick;
         end
         rdata_reg <= rd_i ? rd_mux : 16'h0000;
      end
   end
   assign rdata_o = rdata_reg;
   // level interrupt: any unmasked sticky bit
   assign irq_o = |(status_reg & mask_reg);

   // assertions
   pend_on_trig_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      hit[0] |=> slice_reg[0].pending) else $error("pending not set by trigger");
   pend_clear_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      done_vec[1] && !hit[1] |=> !slice_reg[1].pending) else $error("pending not cleared on done");
   swtrg_clear_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      slice_reg[2].pending && slice_reg[2].soft_trig |=> !slice_reg[2].soft_trig)
      else $error("soft trigger not self-cleared");
   sel_off_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      slice_reg[0].sel == 5'h00 && !slice_reg[0].pending |=> !slice_reg[0].pending)
      else $error("disabled pair became pending");
   soft_route_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      slice_reg[1].sel == 5'h01 && slice_reg[1].soft_trig |-> hit[1]) else $error("own soft trigger lost");
   reserved_code_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      slice_reg[2].sel == 5'h0D |-> !hit[2]) else $error("reserved code triggered");
   tmr2_route_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      slice_reg[0].sel == 5'h1F |-> hit[0] == trig_i.tmr2_period) else $error("timer2 route wrong");
   prio_order_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      conv_req_o && slice_reg[0].pending |-> conv_pair_o == 2'h0) else $error("priority order wrong");
   irq_raise_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      done_vec[0] && slice_reg[0].irq_en && mask_reg[0] && !wr_mask |=> irq_o) else $error("interrupt not raised");
endmodule
`default_nettype wire

/* dv/aptc_seq_model.sv */
// behavioural conversion sequencer facing the pair trigger block
`timescale 1ns/10ps
`default_nettype none
module aptc_seq_model (
   input wire logic clock_i, // system clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic req_i, // conversion request from block
   input wire logic [3:0] delay_i, // conversion length in cycles
   output logic ack_o, // request accepted
   output logic done_o // one-cycle completion pulse
);
   logic busy_reg;
   logic [3:0] cnt_reg;
   // accept at once when idle, so one pair is in flight at most
   assign ack_o = req_i & ~busy_reg;
   // count the conversion down, then pulse done once
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_reg <= 1'b0;
         cnt_reg <= 4'h0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (ack_o) begin
            busy_reg <= 1'b1;
            cnt_reg <= delay_i;
         end else if (busy_reg && cnt_reg == 4'h0) begin
            busy_reg <= 1'b0;
            done_o <= 1'b1;
         end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* dv/aptc_pair_trigger_tb.sv */
// self-checking bench for the pair trigger control block
`include "aptc_map.svh"
`timescale 1ns/10ps
`default_nettype none
module aptc_pair_trigger_tb;
   import aptc_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, req, ack, done, irq;
   logic [3:0] addr = 4'h0, dly = 4'h2;
   logic [15:0] wdata = 16'h0000, rdata;
   logic [1:0] pair;
   aptc_trig_t trig = '0;
   logic [1:0] acks[$];
   int errors = 0, cmp_count = 0, n;
   aptc_pair_trigger uut (.clock_i(clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .trig_i(trig), .conv_req_o(req), .conv_pair_o(pair), .conv_ack_i(ack),
      .conv_done_i(done), .irq_o(irq));
   aptc_seq_model seq (.clock_i(clk), .arst_n_i(arst_n), .req_i(req), .delay_i(dly), .ack_o(ack), .done_o(done));
   initial begin
      forever #2 clk = ~clk;
   end
   // log the pair handed over at each accepted request
   always @(posedge clk) begin
      if (arst_n && req === 1'b1 && ack === 1'b1) acks.push_back(pair);
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic pulse(input aptc_trig_t t);
      @(posedge clk);
      trig <= t;
      @(posedge clk);
      trig <= '0;
   endtask
   // the one source that a selector code should respond to; every source for codes 0 and 13
   function automatic aptc_trig_t src(input int c);
      aptc_trig_t t;
      t = '0;
      if (c == 0 || c == 13) t = '1;
      else if (c == 2) t.global_soft = 1'b1;
      else if (c == 3) t.special_event = 1'b1;
      else if (c >= 4 && c <= 11) t.pwm_primary[c-4] = 1'b1;
      else if (c == 12) t.tmr1_period = 1'b1;
      else if (c >= 14 && c <= 22) t.pwm_secondary[c-14] = 1'b1;
      else if (c >= 23 && c <= 30) t.pwm_climit[c-23] = 1'b1;
      else if (c == 31) t.tmr2_period = 1'b1;
      return t;
   endfunction
   task automatic test_done;
      if (errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      test_done;
   end
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      // reset contents, and an unmapped word
      for (int a = 0; a < 4; a++) rdc(4'(a), 16'h0000);
      rdc(4'h9, 16'h0000);
      // software trigger on pair8, interrupt masked then unmasked
      wrr(`APTC_OFF_CTRL_8_9, 16'h00A1);
      repeat (20) @(posedge clk);
      rdc(`APTC_OFF_CTRL_8_9, 16'h0081);
      chk(16'(acks.size()), 16'h0001);
      chk(16'(acks[0]), 16'h0000);
      rdc(`APTC_OFF_IRQ_STATUS, 16'h0001);
      chk(16'(irq), 16'h0000);
      wrr(`APTC_OFF_IRQ_MASK, 16'h0001);
      #1 chk(16'(irq), 16'h0001);
      wrr(`APTC_OFF_IRQ_STATUS, 16'h0001);
      #1 chk(16'(irq), 16'h0000);
      rdc(`APTC_OFF_IRQ_STATUS, 16'h0000);
      // every selector code on pair10; codes 0 and 13 see all sources at once
      for (int c = 0; c < 32; c++) begin
         n = acks.size();
         if (c == 1) wrr(`APTC_OFF_CTRL_10_11, 16'h0021);
         else begin
            wrr(`APTC_OFF_CTRL_10_11, 16'(c));
            pulse(src(c));
         end
         repeat (12) @(posedge clk);
         chk(16'(acks.size() - n), (c == 0 || c == 13) ? 16'h0000 : 16'h0001);
      end
      chk(16'(acks[acks.size()-1]), 16'h0001);
      rdc(`APTC_OFF_IRQ_STATUS, 16'h0000);
      // layout, read-only pending, and three pairs pending together
      dly <= 4'h6;
      wrr(`APTC_OFF_CTRL_10_11, 16'h5F5F);
      wrr(`APTC_OFF_CTRL_8_9, 16'hFF1F);
      rdc(`APTC_OFF_CTRL_10_11, 16'h1F1F);
      rdc(`APTC_OFF_CTRL_8_9, 16'h1F1F);
      acks.delete();
      pulse(src(31));
      rdc(`APTC_OFF_CTRL_10_11, 16'h5F5F);
      repeat (60) @(posedge clk);
      chk(16'(acks.size()), 16'h0003);
      for (int i = 0; i < 3; i++) chk(16'(acks[i]), 16'(i));
      rdc(`APTC_OFF_CTRL_10_11, 16'h1F1F);
      test_done;
   end
endmodule
`default_nettype wire
